// >>> core/gpio_pkg.sv
package gpio_pkg;

  // Register addresses on the CPU register port.
  localparam logic [11:0] ADDR_PORT_ADDR    = 12'hfd0;
  localparam logic [11:0] ADDR_PORT_CTL     = 12'hfd1;
  localparam logic [11:0] ADDR_IRQ_EDGE_POL = 12'hfcd;
  localparam logic [11:0] ADDR_SHARED_SEL   = 12'hfce;

  // Sub-addresses written to the port address register.
  localparam logic [7:0] SUB_OPEN_DRAIN = 8'h03;
  localparam logic [7:0] SUB_HIGH_DRIVE = 8'h04;
  localparam logic [7:0] SUB_WAKE_SRC   = 8'h05;

  // Value of every register after reset except pin_oe_n, which resets to all ones.
  localparam logic [7:0] RESET_BYTE = 8'h00;

  // One register port request from the CPU.
  typedef struct packed {
    logic [11:0] addr;
    logic        wr;
    logic        rd;
    logic [7:0]  wdata;
  } reg_req_type;

  // Per-pin driver settings that leave the block.
  typedef struct packed {
    logic [7:0] high_drive;
    logic [7:0] open_drain;
  } pin_cfg_type;

endpackage

// >>> core/edge_pulse_bank.sv
`timescale 1ns/1ns
`default_nettype none

module edge_pulse_bank (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic [7:0] level,
  output var  logic [7:0] pulse
);

  logic [7:0] prev;

  // Previous level of each line; reset low so a line high at reset fires once.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      prev <= gpio_pkg::RESET_BYTE;
    end else begin
      prev <= level;
    end
  end

  // One-cycle pulse on each low-to-high step of a line.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pulse <= gpio_pkg::RESET_BYTE;
    end else begin
      pulse <= level & ~prev;
    end
  end

endmodule // edge_pulse_bank

`default_nettype wire

// >>> core/gpio_drive_wake_edge_irq.sv
// What this block does
// [RULE_01] Sub-address 04H in port address reaches high-drive enable via port control.
// [RULE_02] High-drive bit 1 selects high current, 0 keeps standard drive.
// [RULE_03] High-drive acts on the pin driver, alternate functions included.
// [RULE_04] Sub-address 05H in port address reaches wake source enable via port control.
// [RULE_05] Wake enable bit 1 makes the pin a stop recovery source, 0 excludes it.
// [RULE_06] In stop, any transition on an enabled wake pin starts recovery.
// [RULE_07] Open-drain bit 1 turns off source current; 0 keeps push-pull output.
// [RULE_08] Edge polarity 0 interrupts on falling edge, 1 on rising, pins 0 to 7.
// [RULE_09] Shared selector picks port A pin or alternate source per shared interrupt.
// [RULE_10] Switching shared source may itself raise a request when levels differ.
// [RULE_11] Software disables a shared interrupt before changing its source.
// [RULE_12] Pin levels are synchronised first; an edge gives a one-cycle request.
// [RULE_13] Port control accesses reach only the sub-register the address selects.
`timescale 1ns/1ns
`default_nettype none

module gpio_drive_wake_edge_irq (
  input  wire logic                  mclk,
  input  wire logic                  rst,
  input  wire gpio_pkg::reg_req_type reg_req,
  output var  logic [7:0]            reg_rdata,
  input  wire logic [7:0]            port_a_pin,
  input  wire logic [7:0]            pin_data,
  input  wire logic [7:0]            pin_dir,
  output var  logic [7:0]            pin_out,
  output var  logic [7:0]            pin_oe_n,
  output var  gpio_pkg::pin_cfg_type pin_cfg,
  input  wire logic [7:0]            alt_irq_src,
  output var  logic [7:0]            shared_pin_irq,
  input  wire logic                  stop_mode,
  output var  logic                  stop_wake
);

  logic [7:0] port_addr;
  logic [7:0] high_drive_bits;
  logic [7:0] wake_source_bits;
  logic [7:0] open_drain_bits;
  logic [7:0] edge_polarity_bits;
  logic [7:0] shared_irq_selector;
  logic [7:0] pin_meta;
  logic [7:0] pin_sync;
  logic [7:0] pin_prev;
  logic [7:0] sel_level;
  logic       ctl_wr;

  // True when a port control access targets the given sub-register.
  function automatic logic sub_hit(input logic [7:0] addr, input logic [7:0] code);
    sub_hit = (addr == code);
  endfunction

  assign ctl_wr = reg_req.wr && (reg_req.addr == gpio_pkg::ADDR_PORT_CTL);

  // Directly addressed registers.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      port_addr           <= gpio_pkg::RESET_BYTE;
      edge_polarity_bits  <= gpio_pkg::RESET_BYTE;
      shared_irq_selector <= gpio_pkg::RESET_BYTE;
    end else if (reg_req.wr) begin
      if (reg_req.addr == gpio_pkg::ADDR_PORT_ADDR) begin
        port_addr <= reg_req.wdata;
      end
      if (reg_req.addr == gpio_pkg::ADDR_IRQ_EDGE_POL) begin
        edge_polarity_bits <= reg_req.wdata;
      end
      // [RULE_09] selector write
      if (reg_req.addr == gpio_pkg::ADDR_SHARED_SEL) begin
        shared_irq_selector <= reg_req.wdata;
      end
    end
  end

  // Sub-registers behind the port control register; only the selected one moves.
  // [RULE_01] high-drive sub-address
  // [RULE_04] wake sub-address
  // [RULE_13] selected sub-register only
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      high_drive_bits  <= gpio_pkg::RESET_BYTE;
      wake_source_bits <= gpio_pkg::RESET_BYTE;
      open_drain_bits  <= gpio_pkg::RESET_BYTE;
    end else if (ctl_wr) begin
      if (sub_hit(port_addr, gpio_pkg::SUB_HIGH_DRIVE)) begin
        high_drive_bits <= reg_req.wdata;
      end
      if (sub_hit(port_addr, gpio_pkg::SUB_WAKE_SRC)) begin
        wake_source_bits <= reg_req.wdata;
      end
      if (sub_hit(port_addr, gpio_pkg::SUB_OPEN_DRAIN)) begin
        open_drain_bits <= reg_req.wdata;
      end
    end
  end

  // Read data is registered; unmapped addresses and sub-addresses read zero.
  // [RULE_13] read path selection
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      reg_rdata <= gpio_pkg::RESET_BYTE;
    end else if (reg_req.rd) begin
      case (reg_req.addr)
        gpio_pkg::ADDR_PORT_ADDR:    reg_rdata <= port_addr;
        gpio_pkg::ADDR_IRQ_EDGE_POL: reg_rdata <= edge_polarity_bits;
        gpio_pkg::ADDR_SHARED_SEL:   reg_rdata <= shared_irq_selector;
        gpio_pkg::ADDR_PORT_CTL: begin
          if (sub_hit(port_addr, gpio_pkg::SUB_HIGH_DRIVE)) begin
            reg_rdata <= high_drive_bits;
          end else if (sub_hit(port_addr, gpio_pkg::SUB_WAKE_SRC)) begin
            reg_rdata <= wake_source_bits;
          end else if (sub_hit(port_addr, gpio_pkg::SUB_OPEN_DRAIN)) begin
            reg_rdata <= open_drain_bits;
          end else begin
            reg_rdata <= gpio_pkg::RESET_BYTE;
          end
        end
        default: reg_rdata <= gpio_pkg::RESET_BYTE;
      endcase
    end
  end

  // Two-stage synchroniser; pin_meta feeds pin_sync and nothing else.
  // [RULE_12] input synchroniser
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pin_meta <= gpio_pkg::RESET_BYTE;
      pin_sync <= gpio_pkg::RESET_BYTE;
      pin_prev <= gpio_pkg::RESET_BYTE;
    end else begin
      pin_meta <= port_a_pin;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  // Pin driver; settings bypass the function mux so alternate functions see them too.
  // [RULE_02] drive strength out
  // [RULE_03] acts on pin directly
  // [RULE_07] open-drain source off
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pin_out  <= gpio_pkg::RESET_BYTE;
      pin_oe_n <= ~gpio_pkg::RESET_BYTE;
      pin_cfg  <= '0;
    end else begin
      pin_out  <= pin_data;
      pin_oe_n <= ~(pin_dir & ~(open_drain_bits & pin_data));
      pin_cfg  <= '{high_drive: high_drive_bits, open_drain: open_drain_bits};
    end
  end

  // Any edge on an enabled pin while stopped requests recovery.
  // [RULE_05] per-pin enable
  // [RULE_06] both edges wake
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      stop_wake <= 1'b0;
    end else begin
      stop_wake <= stop_mode && |((pin_sync ^ pin_prev) & wake_source_bits);
    end
  end

  // Polarity folds a falling edge into a rising one; the mux sits before the
  // edge detector, so a source switch from a low to a high level fires a request.
  // [RULE_08] edge polarity
  // [RULE_09] source mux
  // [RULE_10] switch may fire
  assign sel_level = (shared_irq_selector & ~(pin_sync ^ edge_polarity_bits))
                   | (~shared_irq_selector & alt_irq_src);

  // [RULE_12] single-cycle pulse
  edge_pulse_bank u_edges (
    .mclk  (mclk),
    .rst   (rst),
    .level (sel_level),
    .pulse (shared_pin_irq)
  );

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence ctl_write_to(logic [7:0] code);
    ctl_wr && port_addr == code;
  endsequence

  // Pin 7 is watched for falling edges, as it is the line left at polarity 0 in normal use.
  sequence pin7_falls_on_port;
    $fell(pin_sync[7]) && shared_irq_selector[7] && !edge_polarity_bits[7]
      && $stable(shared_irq_selector) && $stable(edge_polarity_bits);
  endsequence

  sequence pin0_rises_on_port;
    $rose(pin_sync[0]) && shared_irq_selector[0] && edge_polarity_bits[0]
      && $stable(shared_irq_selector) && $stable(edge_polarity_bits);
  endsequence

  AST_HIGH_DRIVE_WRITE: assert property ( // [RULE_01]
    ctl_write_to(gpio_pkg::SUB_HIGH_DRIVE) |=> ##1 pin_cfg.high_drive == $past(reg_req.wdata, 2))
    else $error("High-drive write did not reach the pin driver.");

  AST_WAKE_WRITE: assert property ( // [RULE_04]
    ctl_write_to(gpio_pkg::SUB_WAKE_SRC) |=> wake_source_bits == $past(reg_req.wdata))
    else $error("Wake source write was lost.");

  AST_SUB_ISOLATION: assert property ( // [RULE_13]
    ctl_wr && port_addr != gpio_pkg::SUB_HIGH_DRIVE |=> $stable(high_drive_bits))
    else $error("High-drive changed on a write to another sub-register.");

  AST_OPEN_DRAIN_HIGH: assert property ( // [RULE_07]
    open_drain_bits[0] && pin_data[0] && pin_dir[0] |=> pin_oe_n[0] && pin_out[0])
    else $error("Open-drain pin still sources current.");

  AST_PUSH_PULL_HIGH: assert property ( // [RULE_07]
    !open_drain_bits[4] && pin_data[4] && pin_dir[4] |=> !pin_oe_n[4])
    else $error("Push-pull pin not driven high.");

  AST_WAKE_ON_EDGE: assert property ( // [RULE_06]
    stop_mode && wake_source_bits[2] && $changed(pin_sync[2]) |=> stop_wake)
    else $error("Enabled pin transition in stop did not wake.");

  AST_NO_WAKE_DISABLED: assert property ( // [RULE_05]
    wake_source_bits == gpio_pkg::RESET_BYTE |=> !stop_wake)
    else $error("Wake raised with no pin enabled.");

  AST_FALL_IRQ: assert property ( // [RULE_08]
    pin7_falls_on_port |=> shared_pin_irq[7])
    else $error("Falling edge missed with polarity 0.");

  AST_RISE_IRQ: assert property ( // [RULE_08]
    pin0_rises_on_port |=> shared_pin_irq[0])
    else $error("Rising edge missed with polarity 1.");

  AST_ALT_SOURCE: assert property ( // [RULE_09]
    !shared_irq_selector[1] && $stable(shared_irq_selector) && $rose(alt_irq_src[1])
      |=> shared_pin_irq[1])
    else $error("Alternate source edge not passed to shared interrupt.");

  AST_SINGLE_PULSE: assert property ( // [RULE_12]
    shared_pin_irq[0] |=> !shared_pin_irq[0])
    else $error("Shared interrupt pulse longer than one cycle.");

  AST_POL_READBACK: assert property ( // [RULE_08]
    reg_req.rd && reg_req.addr == gpio_pkg::ADDR_IRQ_EDGE_POL && !reg_req.wr
      |=> reg_rdata == edge_polarity_bits)
    else $error("Edge polarity readback wrong.");

endmodule // gpio_drive_wake_edge_irq

`default_nettype wire

// >>> tb/pin_env_model.sv
`timescale 1ns/1ns
`default_nettype none

module pin_env_model (
  input  wire logic [7:0] level_req,
  output var  logic [7:0] port_a_pin
);
  // Outside circuitry moves the pins 3 ns after the bench asks.
  // The pins then change away from any clock edge, so the synchroniser is exercised.
  initial port_a_pin = 8'h00;
  always @(level_req) port_a_pin <= #3 level_req;
endmodule // pin_env_model

`default_nettype wire

// >>> tb/gpio_drive_wake_edge_irq_tb_top.sv
`timescale 1ns/1ns
`default_nettype none

module gpio_drive_wake_edge_irq_tb_top;
  logic                  mclk = 1'b0;
  logic                  rst = 1'b1;
  gpio_pkg::reg_req_type reg_req = '0;
  logic [7:0]            reg_rdata;
  logic [7:0]            level_req = 8'h00;
  logic [7:0]            port_a_pin;
  logic [7:0]            pin_data = 8'h00;
  logic [7:0]            pin_dir = 8'h00;
  logic [7:0]            pin_out;
  logic [7:0]            pin_oe_n;
  gpio_pkg::pin_cfg_type pin_cfg;
  logic [7:0]            alt_irq_src = 8'h00;
  logic [7:0]            shared_pin_irq;
  logic                  stop_mode = 1'b0;
  logic                  stop_wake;
  int                    n_fail = 0;
  int                    compares = 0;

  // The clock toggles every half period of 4 ns.
  always #4 mclk = ~mclk;

  pin_env_model i_pin_env_model (.level_req(level_req), .port_a_pin(port_a_pin));

  gpio_drive_wake_edge_irq i_gpio_drive_wake_edge_irq (
    .mclk(mclk), .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .port_a_pin(port_a_pin), .pin_data(pin_data), .pin_dir(pin_dir),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_cfg(pin_cfg),
    .alt_irq_src(alt_irq_src), .shared_pin_irq(shared_pin_irq),
    .stop_mode(stop_mode), .stop_wake(stop_wake)
  );

  // One compare; an unknown never counts as a match.
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  // A write is a single strobe cycle; the write lands at the edge that takes it.
  task automatic reg_wr(input logic [11:0] addr, input logic [7:0] data);
    @(posedge mclk) reg_req <= '{addr: addr, wr: 1'b1, rd: 1'b0, wdata: data};
    @(posedge mclk) reg_req.wr <= 1'b0;
  endtask

  // Read data is registered, so it is sampled just after the taking edge.
  task automatic reg_rd(input logic [11:0] addr, output logic [7:0] data);
    @(posedge mclk) reg_req <= '{addr: addr, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(posedge mclk) reg_req.rd <= 1'b0;
    #1 data = reg_rdata;
  endtask

  // Selects a sub-register, then reads it through port control.
  task automatic sub_rd(input logic [7:0] sub, input logic [7:0] exp);
    logic [7:0] d;
    reg_wr(gpio_pkg::ADDR_PORT_ADDR, sub);
    reg_rd(gpio_pkg::ADDR_PORT_CTL, d);
    check(d, exp);
  endtask

  // Watches eight cycles: requests seen, pulse cycles and wake pulses.
  task automatic watch(input logic [7:0] exp_irq, input logic [7:0] exp_wake);
    logic [7:0] acc;
    logic [7:0] cyc;
    logic [7:0] wk;
    acc = 8'h00;
    cyc = 8'h00;
    wk = 8'h00;
    repeat (8) begin
      @(posedge mclk) #1;
      acc = acc | shared_pin_irq;
      if (shared_pin_irq !== 8'h00) cyc++;
      if (stop_wake === 1'b1) wk++;
    end
    check(acc, exp_irq);
    check(cyc, (exp_irq != 8'h00) ? 8'h01 : 8'h00);
    check(wk, exp_wake);
  endtask

  task automatic report_and_stop;
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // A hang is cut short here and counted as a mismatch.
  initial begin
    #200000;
    n_fail++;
    report_and_stop();
  end

  // Main sequence.
  initial begin
    logic [7:0] d;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    check(pin_oe_n, 8'hff);
    check(pin_cfg.high_drive, 8'h00);
    check(pin_cfg.open_drain, 8'h00);
    reg_rd(gpio_pkg::ADDR_IRQ_EDGE_POL, d);
    check(d, 8'h00);
    sub_rd(gpio_pkg::SUB_HIGH_DRIVE, 8'h00);
    sub_rd(gpio_pkg::SUB_WAKE_SRC, 8'h00);
    $display("test reset done");
    reg_wr(gpio_pkg::ADDR_PORT_ADDR, gpio_pkg::SUB_HIGH_DRIVE);
    reg_wr(gpio_pkg::ADDR_PORT_CTL, 8'ha5);
    reg_wr(gpio_pkg::ADDR_PORT_ADDR, gpio_pkg::SUB_WAKE_SRC);
    reg_wr(gpio_pkg::ADDR_PORT_CTL, 8'h3c);
    reg_wr(gpio_pkg::ADDR_PORT_ADDR, 8'h06);
    reg_wr(gpio_pkg::ADDR_PORT_CTL, 8'h77);
    sub_rd(gpio_pkg::SUB_HIGH_DRIVE, 8'ha5);
    sub_rd(gpio_pkg::SUB_WAKE_SRC, 8'h3c);
    sub_rd(8'h06, 8'h00);
    reg_rd(12'h100, d);
    check(d, 8'h00);
    check(pin_cfg.high_drive, 8'ha5);
    $display("test sub-registers done");
    reg_wr(gpio_pkg::ADDR_PORT_ADDR, gpio_pkg::SUB_OPEN_DRAIN);
    reg_wr(gpio_pkg::ADDR_PORT_CTL, 8'h0f);
    pin_dir <= 8'hff;
    pin_data <= 8'h55;
    repeat (2) @(posedge mclk);
    #1 check(pin_oe_n, 8'h05);
    check(pin_out, 8'h55);
    check(pin_cfg.open_drain, 8'h0f);
    @(posedge mclk) pin_dir <= 8'h0f;
    repeat (2) @(posedge mclk);
    #1 check(pin_oe_n, 8'hf5);
    check(pin_cfg.high_drive, 8'ha5);
    $display("test open drain done");
    reg_wr(gpio_pkg::ADDR_SHARED_SEL, 8'hff);
    watch(8'hff, 8'h00);
    reg_wr(gpio_pkg::ADDR_IRQ_EDGE_POL, 8'h0f);
    watch(8'h00, 8'h00);
    @(posedge mclk) level_req <= 8'hff;
    watch(8'h0f, 8'h00);
    @(posedge mclk) level_req <= 8'h00;
    watch(8'hf0, 8'h00);
    // alternate source selection
    // This switch only drops the selected levels from f0 to 00, so nothing may fire.
    reg_wr(gpio_pkg::ADDR_SHARED_SEL, 8'h00);
    watch(8'h00, 8'h00);
    @(posedge mclk) alt_irq_src <= 8'h83;
    watch(8'h83, 8'h00);
    $display("test interrupts done");
    @(posedge mclk) level_req <= 8'h04;
    watch(8'h00, 8'h00);
    @(posedge mclk) stop_mode <= 1'b1;
    level_req <= 8'h00;
    watch(8'h00, 8'h01);
    @(posedge mclk) level_req <= 8'h01;
    watch(8'h00, 8'h00);
    @(posedge mclk) level_req <= 8'h05;
    watch(8'h00, 8'h01);
    $display("test wake done");
    report_and_stop();
  end
endmodule // gpio_drive_wake_edge_irq_tb_top

`default_nettype wire
